// ### hdl/srd_pkg.sv
// Shared constants and types for the receiver clock-mode and stream-detect block.
package srd_pkg;

  // Time base and frame spacing used by the lock monitor.
  localparam int CLK_NS        = 100;
  localparam int FRAME_MIN_NS  = 20000;
  localparam int FRAME_MAX_NS  = 32500;
  localparam int FRAME_MIN_CYC = (FRAME_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_MAX_CYC = FRAME_MAX_NS / CLK_NS;
  localparam logic [8:0] GAP_MIN    = 9'(FRAME_MIN_CYC);
  localparam logic [8:0] GAP_MAX    = 9'(FRAME_MAX_CYC);
  localparam logic [2:0] RELOCK_CNT = 3'h4;

  // Stream detection.
  localparam logic [12:0] IDLE_LAST   = 13'hFFF;
  localparam logic [15:0] NP_SYNC_A   = 16'h7872;
  localparam logic [15:0] NP_SYNC_B   = 16'h4E1F;
  localparam logic [15:0] CDS14_A     = 16'h1FFF;
  localparam logic [15:0] CDS14_B     = 16'hE800;
  localparam logic [15:0] CDS16_A     = 16'h7FFE;
  localparam logic [15:0] CDS16_B     = 16'h8001;

  // Clock modes and reference selections.
  localparam logic [1:0] MODE_PLL  = 2'h0;
  localparam logic [1:0] MODE_XTAL = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_MON  = 2'h3;
  localparam logic [1:0] REF_CS    = 2'h3;

  // Rate codes and ratios.
  localparam logic [3:0]  FS_44K1  = 4'h0;
  localparam logic [3:0]  FS_RSVD  = 4'h1;
  localparam logic [3:0]  FS_48K   = 4'h2;
  localparam logic [3:0]  FS_32K   = 4'h3;
  localparam logic [10:0] RATIO_PLL = 11'h100;
  localparam logic [7:0]  METER_FRAMES = 8'hFF;

  // Pre-emphasis patterns, listed as first bit, second bit, third bit.
  localparam logic [2:0] EMPH_CON = 3'h4;
  localparam logic [2:0] EMPH_PRO = 3'h6;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] ratio;
    logic       div;
    logic       ext;
    logic [1:0] freqRef;
    logic       chSel;
  } srd_cfg_t;

  localparam srd_cfg_t CFG_RST = '{mode: 2'h0, ratio: 2'h1, div: 1'h0, ext: 1'h0, freqRef: 2'h0, chSel: 1'h0};

  typedef struct packed {
    logic [7:0] ch1Byte0;
    logic [7:0] ch2Byte0;
    logic [7:0] byte3;
    logic [7:0] byte4;
  } srd_cs_t;

  typedef enum logic [2:0] {
    BC_IDLE = 3'b001,
    BC_INFO = 3'b010,
    BC_LEN  = 3'b100
  } srd_burst_t;

endpackage

// ### hdl/srd_rate_meter.sv
// Sampling-rate measurement against the reference oscillator.
module srd_rate_meter (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       soft_reset_n,
  // Measurement
  input  wire logic       clear,
  input  wire logic       frameStart,
  input  wire logic       oscTick,
  input  wire logic [1:0] freqRef,
  output logic [3:0]      rateCode
);

  typedef struct packed {
    logic [7:0]  frames;
    logic [11:0] ticks;
    logic [3:0]  code;
  } srd_meter_t;

  srd_meter_t q;
  srd_meter_t d;

  // The oscillator tick runs at reference/256, so 256 frames give about 256fs/fs counts.
  function automatic logic [3:0] classify(input logic [11:0] t, input logic [1:0] sel);
    int n48;
    int n44;
    int n32;
    int v;
    n48 = (sel == 2'h2) ? 512 : (sel == 2'h1) ? 256 : 235;
    n44 = (sel == 2'h2) ? 557 : (sel == 2'h1) ? 279 : 256;
    n32 = (sel == 2'h2) ? 768 : (sel == 2'h1) ? 384 : 352;
    v   = int'(t);
    if (v < n48 - n48 / 8 || v > n32 + n32 / 8) begin
      classify = srd_pkg::FS_RSVD;
    end else if (v * 2 < n48 + n44) begin
      classify = srd_pkg::FS_48K;
    end else if (v * 2 < n44 + n32) begin
      classify = srd_pkg::FS_44K1;
    end else begin
      classify = srd_pkg::FS_32K;
    end
  endfunction

  always_comb begin
    d = q;
    if (oscTick && q.ticks != 12'hFFF) begin
      d.ticks = q.ticks + 12'h001;
    end
    if (frameStart) begin
      d.frames = q.frames + 8'h01;
      if (q.frames == srd_pkg::METER_FRAMES) begin
        d.code  = classify(q.ticks, freqRef);
        d.ticks = 12'h000;
      end
    end
    if (clear) begin
      d = '{frames: 8'h00, ticks: 12'h000, code: srd_pkg::FS_44K1};
    end
  end

  always_ff @(posedge ref_clk or negedge soft_reset_n) begin
    if (!soft_reset_n) begin
      q <= '{frames: 8'h00, ticks: 12'h000, code: srd_pkg::FS_44K1};
    end else begin
      q <= d;
    end
  end

  assign rateCode = q.code;

endmodule

// ### hdl/srd_mclk_switch.sv
// Glitch-free master clock source switch with optional halving of the oscillator path.
module srd_mclk_switch (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic soft_reset_n,
  // Sources and control
  input  wire logic enable,
  input  wire logic pllTick,
  input  wire logic oscTick,
  input  wire logic useOsc,
  input  wire logic divHalf,
  // Output
  output logic      mck,
  output logic      onOsc
);

  typedef struct packed {
    logic mck;
    logic onOsc;
    logic half;
  } srd_sw_t;

  srd_sw_t q;
  srd_sw_t d;
  logic    tick;

  always_comb begin
    d    = q;
    tick = q.onOsc ? (oscTick && (!divHalf || q.half)) : pllTick;
    if (oscTick) begin
      d.half = !q.half;
    end
    // The source only changes while the output is low, so the change itself never truncates a high phase.
    if (useOsc != q.onOsc && !q.mck) begin
      d.onOsc = useOsc;
    // A source that stops while the output is high would hold it high forever, so a pending switch lets
    // either source end that high phase; it ends at the first tick of either, so it can be shorter than a normal phase.
    end else if (tick || (useOsc != q.onOsc && (pllTick || oscTick))) begin
      d.mck = !q.mck;
    end
    if (!enable) begin
      d = '{mck: 1'h0, onOsc: 1'h0, half: 1'h0};
    end
  end

  always_ff @(posedge ref_clk or negedge soft_reset_n) begin
    if (!soft_reset_n) begin
      q <= '{mck: 1'h0, onOsc: 1'h0, half: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign mck   = q.mck;
  assign onOsc = q.onOsc;

endmodule

// ### hdl/srd_clock_stream.sv
// Clock mode control, lock monitor, rate and pre-emphasis detection, bitstream detection.
module srd_clock_stream (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            soft_reset_n,
  // Pins
  input  wire logic            powerDownN,
  input  wire logic            auxAudioIn,
  // Control bits
  input  wire logic            softResetN,
  input  wire logic            partialPowerN,
  input  wire logic [1:0]      clockModeSel,
  input  wire logic [1:0]      crystalRatioSel,
  input  wire logic            divideSel,
  input  wire logic            extClockSel,
  input  wire logic [1:0]      freqReferenceSel,
  input  wire logic            statusChannelSel,
  // Receiver front end
  input  wire logic            frameStart,
  input  wire logic            wordValid,
  input  wire logic [15:0]     rxWord,
  input  wire logic            rxAudioBit,
  input  wire logic            pllTick,
  input  wire logic            oscTick,
  input  wire srd_pkg::srd_cs_t chanStatus,
  // Status
  output logic                 pllUnlocked,
  output logic                 compressedStreamFlag,
  output logic                 cdSurroundStreamFlag,
  output logic [15:0]          burstInfo,
  output logic [15:0]          burstLength,
  output logic [3:0]           detectedRateCode,
  output logic                 preemphFlag,
  // Clock and audio
  output logic                 masterClockOut,
  output logic                 audioSerialOut,
  output logic                 pllEnable,
  output logic                 oscEnable,
  output logic                 oscOut,
  output logic                 auxSelected,
  output logic [10:0]          masterClockRatio
);

  typedef struct packed {
    logic [1:0]         pwrSync;
    logic [1:0]         auxSync;
    srd_pkg::srd_cfg_t  cfg;
    logic [8:0]         gapCnt;
    logic [2:0]         goodCnt;
    logic               unlocked;
    logic [3:0][15:0]   hist;
    logic               npFlag;
    logic [12:0]        npIdle;
    logic               cdFlag;
    logic [12:0]        cdIdle;
    srd_pkg::srd_burst_t burst;
    logic [15:0]        info;
    logic [15:0]        len;
    logic [3:0]         rate;
    logic               emph;
    logic               audio;
    logic               pllEn;
    logic               oscEn;
    logic               oscOut;
    logic               auxSel;
    logic [10:0]        ratio;
  } srd_state_t;

  localparam srd_state_t ST_RST = '{
    pwrSync: 2'h0, auxSync: 2'h0, cfg: srd_pkg::CFG_RST, gapCnt: 9'h000, goodCnt: 3'h0,
    unlocked: 1'h1, hist: 64'h0, npFlag: 1'h0, npIdle: 13'h0000, cdFlag: 1'h0,
    cdIdle: 13'h0000, burst: srd_pkg::BC_IDLE, info: 16'h0000, len: 16'h0000,
    rate: 4'h0, emph: 1'h0, audio: 1'h0, pllEn: 1'h0, oscEn: 1'h0, oscOut: 1'h0,
    auxSel: 1'h0, ratio: 11'h000};

  srd_state_t q;
  srd_state_t d;
  logic       pwrOk;
  logic       useOsc;
  logic       pllOn;
  logic       npHit;
  logic       cdHit;
  logic [3:0] meterCode;
  logic       meterClear;

  // Rate from channel status: consumer copies a nibble, professional decodes.
  function automatic logic [3:0] status_rate(input srd_pkg::srd_cs_t cs);
    logic [1:0] pro;
    pro = cs.ch1Byte0[7:6];
    if (!cs.ch1Byte0[0]) begin
      status_rate = cs.byte3[3:0];
    end else if (pro == 2'h1) begin
      status_rate = srd_pkg::FS_44K1;
    end else if (pro == 2'h2) begin
      status_rate = srd_pkg::FS_48K;
    end else if (pro == 2'h3) begin
      status_rate = srd_pkg::FS_32K;
    end else begin
      unique case (cs.byte4[6:3])
        4'hA:    status_rate = 4'h8;
        4'h2:    status_rate = 4'hA;
        4'hB:    status_rate = 4'hC;
        4'h3:    status_rate = 4'hE;
        default: status_rate = srd_pkg::FS_RSVD;
      endcase
    end
  endfunction

  // Pre-emphasis from byte 0 of the chosen channel.
  function automatic logic emph_of(input logic [7:0] b0);
    if (b0[0]) begin
      emph_of = {b0[2], b0[3], b0[4]} == srd_pkg::EMPH_PRO;
    end else begin
      emph_of = {b0[3], b0[4], b0[5]} == srd_pkg::EMPH_CON;
    end
  endfunction

  assign pwrOk      = q.pwrSync[1];
  assign meterClear = !pwrOk || !softResetN || q.unlocked;
  assign pllOn      = partialPowerN && q.cfg.mode != srd_pkg::MODE_XTAL;
  assign useOsc     = q.cfg.mode == srd_pkg::MODE_XTAL || q.cfg.mode == srd_pkg::MODE_MON ||
                      (q.cfg.mode == srd_pkg::MODE_AUTO && q.unlocked);
  assign npHit = wordValid && q.hist[3] == 16'h0000 && q.hist[2] == 16'h0000 &&
                 q.hist[1] == 16'h0000 && q.hist[0] == srd_pkg::NP_SYNC_A && rxWord == srd_pkg::NP_SYNC_B;
  assign cdHit = wordValid && q.hist[0] == srd_pkg::CDS14_A && rxWord == srd_pkg::CDS14_B;

  always_comb begin
    d         = q;
    d.pwrSync = {q.pwrSync[0], powerDownN};
    d.auxSync = {q.auxSync[0], auxAudioIn};
    // Soft reset keeps only the reference and external-clock settings live.
    d.cfg         = srd_pkg::CFG_RST;
    d.cfg.freqRef = freqReferenceSel;
    d.cfg.ext     = extClockSel;
    if (softResetN) begin
      d.cfg.mode  = clockModeSel;
      d.cfg.ratio = crystalRatioSel;
      d.cfg.div   = divideSel;
      d.cfg.chSel = statusChannelSel;
    end
    // Lock monitor: each frame gap must sit inside the window; a few good gaps relock.
    if (!pllOn) begin
      d.gapCnt   = 9'h000;
      d.goodCnt  = 3'h0;
      d.unlocked = 1'h1;
    end else if (frameStart) begin
      d.gapCnt = 9'h000;
      if (q.gapCnt < srd_pkg::GAP_MIN || q.gapCnt > srd_pkg::GAP_MAX) begin
        d.unlocked = 1'h1;
        d.goodCnt  = 3'h0;
      end else if (q.goodCnt == srd_pkg::RELOCK_CNT - 3'h1) begin
        d.unlocked = 1'h0;
      end else begin
        d.goodCnt = q.goodCnt + 3'h1;
      end
    end else if (q.gapCnt > srd_pkg::GAP_MAX) begin
      d.unlocked = 1'h1;
      d.goodCnt  = 3'h0;
    end else begin
      d.gapCnt = q.gapCnt + 9'h001;
    end
    // Idle frame counting; a sync in the expiry cycle wins below.
    if (frameStart && q.npFlag) begin
      d.npIdle = q.npIdle + 13'h0001;
      if (q.npIdle == srd_pkg::IDLE_LAST) begin
        d.npFlag = 1'h0;
        d.npIdle = 13'h0000;
      end
    end
    if (frameStart && q.cdFlag) begin
      d.cdIdle = q.cdIdle + 13'h0001;
      if (q.cdIdle == srd_pkg::IDLE_LAST) begin
        d.cdFlag = 1'h0;
        d.cdIdle = 13'h0000;
      end
    end
    if (wordValid) begin
      d.hist = {q.hist[2:0], rxWord};
      unique case (q.burst)
        srd_pkg::BC_IDLE: d.burst = srd_pkg::BC_IDLE;
        srd_pkg::BC_INFO: begin
          d.info  = rxWord;
          d.burst = srd_pkg::BC_LEN;
        end
        srd_pkg::BC_LEN: begin
          d.len   = rxWord;
          d.burst = srd_pkg::BC_IDLE;
        end
        default: d.burst = srd_pkg::BC_IDLE;
      endcase
    end
    if (npHit) begin
      d.npFlag = 1'h1;
      d.npIdle = 13'h0000;
      d.burst  = srd_pkg::BC_INFO;
    end
    // Only the 14-bit packing arms the surround flag; the 16-bit word pair never matches cdHit.
    if (cdHit) begin
      d.cdFlag = 1'h1;
      d.cdIdle = 13'h0000;
    end
    if (!softResetN) begin
      d.hist   = 64'h0;
      d.npFlag = 1'h0;
      d.npIdle = 13'h0000;
      d.cdFlag = 1'h0;
      d.cdIdle = 13'h0000;
      d.burst  = srd_pkg::BC_IDLE;
      d.info   = 16'h0000;
      d.len    = 16'h0000;
    end
    // Derived outputs, all registered.
    d.rate   = q.cfg.freqRef == srd_pkg::REF_CS ? status_rate(chanStatus) : meterCode;
    d.emph   = emph_of(q.cfg.chSel ? chanStatus.ch2Byte0 : chanStatus.ch1Byte0);
    d.auxSel = useOsc;
    d.pllEn  = pllOn;
    d.oscEn  = !(q.cfg.mode == srd_pkg::MODE_PLL && q.cfg.freqRef == srd_pkg::REF_CS);
    d.oscOut = d.oscEn && !q.cfg.ext;
    d.ratio  = useOsc ? 11'(11'h080 << q.cfg.ratio) >> q.cfg.div : srd_pkg::RATIO_PLL;
    // Audio is held low in soft reset, and while the PLL path has no lock.
    d.audio  = !softResetN ? 1'h0 : useOsc ? q.auxSync[1] : (!q.unlocked && rxAudioBit);
    if (!pwrOk) begin
      d         = ST_RST;
      d.pwrSync = {q.pwrSync[0], powerDownN};
    end
  end

  always_ff @(posedge ref_clk or negedge soft_reset_n) begin
    if (!soft_reset_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  srd_rate_meter uMeter (
    .ref_clk    (ref_clk),
    .soft_reset_n       (soft_reset_n),
    .clear      (meterClear),
    .frameStart (frameStart),
    .oscTick    (oscTick && q.oscEn),
    .freqRef    (q.cfg.freqRef),
    .rateCode   (meterCode)
  );

  srd_mclk_switch uSwitch (
    .ref_clk (ref_clk),
    .soft_reset_n    (soft_reset_n),
    .enable  (pwrOk),
    .pllTick (pllTick && q.pllEn),
    .oscTick (oscTick && q.oscEn),
    .useOsc  (useOsc),
    .divHalf (q.cfg.div),
    .mck     (masterClockOut),
    .onOsc   ()
  );

  assign pllUnlocked          = q.unlocked;
  assign compressedStreamFlag = q.npFlag;
  assign cdSurroundStreamFlag = q.cdFlag;
  assign burstInfo            = q.info;
  assign burstLength          = q.len;
  assign detectedRateCode     = q.rate;
  assign preemphFlag          = q.emph;
  assign audioSerialOut       = q.audio;
  assign pllEnable            = q.pllEn;
  assign oscEnable            = q.oscEn;
  assign oscOut               = q.oscOut;
  assign auxSelected          = q.auxSel;
  assign masterClockRatio     = q.ratio;

  AST_NP_SET: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    npHit && pwrOk && softResetN |=> compressedStreamFlag) else $error("Compressed flag missed sync.");
  AST_NP_HOLD: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    $fell(compressedStreamFlag) |-> $past(frameStart && q.npIdle == 13'hFFF) || $past(!pwrOk || !softResetN))
    else $error("Compressed flag fell early.");
  AST_BURST_LEN: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    q.burst == srd_pkg::BC_LEN && wordValid && !npHit && pwrOk && softResetN |=> burstLength == $past(rxWord))
    else $error("Length word not captured.");
  AST_CD16: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    !cdSurroundStreamFlag && wordValid && q.hist[0] == 16'h7FFE && rxWord == 16'h8001 |=> !cdSurroundStreamFlag)
    else $error("Surround flag armed by 16-bit sync.");
  AST_UNLOCK: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    pwrOk && frameStart && q.gapCnt < srd_pkg::GAP_MIN |=> pllUnlocked) else $error("Short frame gap not flagged.");
  AST_AUX_MODE: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    pwrOk && q.cfg.mode == 2'h1 ##1 pwrOk && q.cfg.mode == 2'h1 |=> auxSelected && !pllEnable)
    else $error("Crystal mode not routing aux.");
  AST_OSC_OFF: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    (q.cfg.mode == 2'h0 && q.cfg.freqRef == 2'h3)[*2] |-> !oscEnable) else $error("Oscillator left on.");
  AST_CONS_RATE: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    pwrOk && q.cfg.freqRef == 2'h3 && !chanStatus.ch1Byte0[0] |=> !pwrOk || detectedRateCode == $past(chanStatus.byte3[3:0]))
    else $error("Consumer rate not copied.");
  AST_POWER_DOWN: assert property (@(posedge ref_clk) disable iff (!soft_reset_n)
    !pwrOk |=> !audioSerialOut && !masterClockOut && !compressedStreamFlag && masterClockRatio == 11'h000)
    else $error("Outputs active in power-down.");

endmodule

// ### test/srd_tx_model.sv
// Behavioural transmitter model: frame preambles, decoded words and free-running clock ticks.
module srd_tx_model (
  // Clock
  input  wire logic ref_clk,
  // Receiver front end
  output logic        frameStart,
  output logic        wordValid,
  output logic [15:0] rxWord,
  output logic        pllTick,
  output logic        oscTick
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] oscPhase;

  initial begin
    frameStart = 1'b0;
    wordValid = 1'b0;
    rxWord = 16'h0000;
    pllTick = 1'b0;
    oscTick = 1'b0;
    oscPhase = 2'h0;
  end

  // Both clocks run free, the oscillator at a third of the reference rate.
  always @(posedge ref_clk) begin
    #1;
    pllTick = ~pllTick;
    oscPhase = (oscPhase == 2'h2) ? 2'h0 : oscPhase + 2'h1;
    oscTick = (oscPhase == 2'h0);
  end

  // One preamble pulse per frame, frames gap cycles apart; caller sits just after an edge.
  task automatic send_frames(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      frameStart = 1'b1;
      @(posedge ref_clk);
      #1;
      frameStart = 1'b0;
      repeat (gap - 1) begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask

  // Words go back to back; released data is inverted so it never looks like a held value.
  task automatic send_words(input logic [15:0] ws [8], input int n);
    wordValid = 1'b1;
    for (int i = 0; i < n; i++) begin
      rxWord = ws[i];
      @(posedge ref_clk);
      #1;
    end
    wordValid = 1'b0;
    rxWord = ~rxWord;
  endtask
endmodule

// ### test/test_srd_clock_stream.sv
// Self-checking bench for the clock-mode and stream-detect block.
module test_srd_clock_stream;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk, soft_reset_n, powerDownN, auxAudioIn, softResetN, partialPowerN;
  logic [1:0] clockModeSel, crystalRatioSel, freqReferenceSel;
  logic divideSel, extClockSel, statusChannelSel, rxAudioBit;
  srd_pkg::srd_cs_t chanStatus;
  logic frameStart, wordValid, pllTick, oscTick;
  logic [15:0] rxWord, burstInfo, burstLength;
  logic pllUnlocked, compressedStreamFlag, cdSurroundStreamFlag, preemphFlag;
  logic masterClockOut, audioSerialOut, pllEnable, oscEnable, oscOut, auxSelected;
  logic [3:0] detectedRateCode;
  logic [10:0] masterClockRatio;
  logic mckPrev;
  logic [10:0] ratE [8] = '{11'h080, 11'h100, 11'h200, 11'h400, 11'h040, 11'h080, 11'h100, 11'h200};
  int errors;
  int numChecks;
  int nTog [2];
  logic [15:0] ws [8];
  logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic auxE [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic pllE [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] b0s [7] = '{8'h00, 8'h00, 8'h00, 8'h41, 8'h81, 8'hC1, 8'h01};
  logic [7:0] b3s [7] = '{8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] b4s [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50};
  logic [3:0] rateE [7] = '{4'h0, 4'h2, 4'h3, 4'h0, 4'h2, 4'h3, 4'h8};
  logic [7:0] c1s [5] = '{8'h08, 8'h00, 8'h00, 8'h0D, 8'h09};
  logic [7:0] c2s [5] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
  logic selE [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic pemE [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  srd_clock_stream srd_clock_stream_inst (.ref_clk(ref_clk), .soft_reset_n(soft_reset_n), .powerDownN(powerDownN),
    .auxAudioIn(auxAudioIn), .softResetN(softResetN), .partialPowerN(partialPowerN),
    .clockModeSel(clockModeSel), .crystalRatioSel(crystalRatioSel), .divideSel(divideSel),
    .extClockSel(extClockSel), .freqReferenceSel(freqReferenceSel), .statusChannelSel(statusChannelSel),
    .frameStart(frameStart), .wordValid(wordValid), .rxWord(rxWord), .rxAudioBit(rxAudioBit),
    .pllTick(pllTick), .oscTick(oscTick), .chanStatus(chanStatus), .pllUnlocked(pllUnlocked),
    .compressedStreamFlag(compressedStreamFlag), .cdSurroundStreamFlag(cdSurroundStreamFlag),
    .burstInfo(burstInfo), .burstLength(burstLength), .detectedRateCode(detectedRateCode),
    .preemphFlag(preemphFlag), .masterClockOut(masterClockOut), .audioSerialOut(audioSerialOut),
    .pllEnable(pllEnable), .oscEnable(oscEnable), .oscOut(oscOut), .auxSelected(auxSelected),
    .masterClockRatio(masterClockRatio));

  srd_tx_model srd_tx_model_inst (.ref_clk(ref_clk), .frameStart(frameStart), .wordValid(wordValid),
    .rxWord(rxWord), .pllTick(pllTick), .oscTick(oscTick));

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  task automatic step(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    numChecks = 0;
    soft_reset_n = 1'b0;
    powerDownN = 1'b1;
    auxAudioIn = 1'b0;
    softResetN = 1'b1;
    partialPowerN = 1'b1;
    clockModeSel = 2'h0;
    crystalRatioSel = 2'h1;
    divideSel = 1'b0;
    extClockSel = 1'b0;
    freqReferenceSel = 2'h2;
    statusChannelSel = 1'b0;
    rxAudioBit = 1'b0;
    chanStatus = '0;
    step(20);
    chk("unlockRst", 16'(pllUnlocked), 16'h0001);
    soft_reset_n = 1'b1;
    step(6);
    chk("ratioPll", 16'(masterClockRatio), 16'h0100);
    srd_tx_model_inst.send_frames(6, 250);
    chk("locked", 16'(pllUnlocked), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      clockModeSel = modes[i];
      step(3);
      chk("auxSel", 16'(auxSelected), 16'(auxE[i]));
      chk("pllEn", 16'(pllEnable), 16'(pllE[i]));
    end
    clockModeSel = 2'h2;
    rxAudioBit = 1'b1;
    // Crystal mode left the monitor unlocked, so auto mode needs fresh frames to relock first.
    srd_tx_model_inst.send_frames(6, 250);
    chk("audioRx", 16'(audioSerialOut), 16'h0001);
    step(100);
    chk("lostLock", 16'(pllUnlocked), 16'h0001);
    chk("autoAux", 16'(auxSelected), 16'h0001);
    srd_tx_model_inst.send_frames(5, 250);
    chk("autoBack", 16'(auxSelected), 16'h0000);
    rxAudioBit = 1'b0;
    ws = '{16'h7FFE, 16'h8001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    srd_tx_model_inst.send_words(ws, 2);
    step(2);
    chk("cd16", 16'(cdSurroundStreamFlag), 16'h0000);
    ws[0] = 16'h1FFF;
    ws[1] = 16'hE800;
    srd_tx_model_inst.send_words(ws, 2);
    step(2);
    chk("cd14", 16'(cdSurroundStreamFlag), 16'h0001);
    ws = '{16'h0000, 16'h0000, 16'h0000, 16'h7872, 16'h4E1F, 16'hA5C3, 16'h0123, 16'h0000};
    srd_tx_model_inst.send_words(ws, 7);
    step(2);
    chk("npFlag", 16'(compressedStreamFlag), 16'h0001);
    chk("info", burstInfo, 16'hA5C3);
    chk("len", burstLength, 16'h0123);
    srd_tx_model_inst.send_frames(4095, 2);
    chk("npHold", 16'(compressedStreamFlag), 16'h0001);
    chk("cdHold", 16'(cdSurroundStreamFlag), 16'h0001);
    srd_tx_model_inst.send_frames(1, 2);
    chk("npIdle", 16'(compressedStreamFlag), 16'h0000);
    chk("cdIdle", 16'(cdSurroundStreamFlag), 16'h0000);
    clockModeSel = 2'h1;
    for (int r = 0; r < 8; r++) begin
      crystalRatioSel = r[1:0];
      divideSel = r[2];
      step(3);
      chk("ratioXtal", 16'(masterClockRatio), 16'(ratE[r]));
    end
    // Halving the oscillator path must leave no more than about half the output toggle count.
    for (int d = 0; d < 2; d++) begin
      divideSel = d[0];
      nTog[d] = 0;
      step(3);
      repeat (60) begin
        mckPrev = masterClockOut;
        step(1);
        nTog[d] += (masterClockOut !== mckPrev) ? 1 : 0;
      end
    end
    chk("mckDiv", 16'(nTog[0] >= 15 && nTog[1] <= nTog[0] / 2 + 2), 16'h0001);
    auxAudioIn = 1'b1;
    step(6);
    chk("audioAux", 16'(audioSerialOut), 16'h0001);
    auxAudioIn = 1'b0;
    clockModeSel = 2'h0;
    freqReferenceSel = 2'h3;
    step(3);
    chk("oscOff", 16'(oscEnable), 16'h0000);
    for (int i = 0; i < 7; i++) begin
      chanStatus = '{ch1Byte0: b0s[i], ch2Byte0: 8'h00, byte3: b3s[i], byte4: b4s[i]};
      step(3);
      chk("rateCs", 16'(detectedRateCode), 16'(rateE[i]));
    end
    for (int i = 0; i < 5; i++) begin
      chanStatus = '{ch1Byte0: c1s[i], ch2Byte0: c2s[i], byte3: 8'h00, byte4: 8'h00};
      statusChannelSel = selE[i];
      step(4);
      chk("preemph", 16'(preemphFlag), 16'(pemE[i]));
    end
    freqReferenceSel = 2'h0;
    extClockSel = 1'b1;
    step(3);
    chk("oscOn", 16'(oscEnable), 16'h0001);
    srd_tx_model_inst.send_words(ws, 7);
    clockModeSel = 2'h1;
    freqReferenceSel = 2'h3;
    softResetN = 1'b0;
    step(4);
    chk("srFlag", 16'(compressedStreamFlag), 16'h0000);
    chk("srInfo", burstInfo, 16'h0000);
    chk("srMode", 16'(auxSelected), 16'h0000);
    chk("srRatio", 16'(masterClockRatio), 16'h0100);
    chk("srRef", 16'(oscEnable), 16'h0000);
    chk("srAudio", 16'(audioSerialOut), 16'h0000);
    softResetN = 1'b1;
    freqReferenceSel = 2'h0;
    // Auto mode keeps the PLL wanted, so only the partial power bit can stop it below.
    clockModeSel = 2'h2;
    step(3);
    partialPowerN = 1'b0;
    step(3);
    chk("ppUnlock", 16'(pllUnlocked), 16'h0001);
    chk("ppPll", 16'(pllEnable), 16'h0000);
    chk("ppAux", 16'(auxSelected), 16'h0001);
    partialPowerN = 1'b1;
    powerDownN = 1'b0;
    step(5);
    chk("pdAux", 16'(auxSelected), 16'h0000);
    chk("pdRatio", 16'(masterClockRatio), 16'h0000);
    chk("pdUnlock", 16'(pllUnlocked), 16'h0001);
    powerDownN = 1'b1;
    step(6);
    chk("pdBack", 16'(auxSelected), 16'h0001);
    tally_and_finish();
  end
endmodule
